// >>> common/irq_io_pkg.sv
/*
 * Constants for the bit-serial interrupt and port interface.
 * Assumes a single 20 MHz system clock and plain pin ports.
 */
`default_nettype none
package irq_io_pkg;
    localparam int SEL_W = 5;
    localparam int NUM_DED_IRQ = 6;
    localparam int NUM_SHARED = 9;
    localparam int NUM_DED_PORT = 7;
    localparam int NUM_IRQ = 15;
    localparam int NUM_PORT = 16;
    localparam logic [4:0] SEL_CONTROL = 5'h00;
    localparam logic [4:0] SEL_SOFT_RESET = 5'h0f;
    localparam logic [4:0] SEL_PORT_BASE = 5'h10;
    localparam logic [3:0] CODE_IDLE = 4'hf;
    localparam logic [3:0] CODE_RESET = 4'h0;
    localparam logic [14:0] MASK_RESET = 15'h0000;
    localparam logic [15:0] PORT_DIR_RESET = 16'h0000;
    localparam logic [15:0] PORT_VAL_RESET = 16'h0000;
    localparam logic CTRL_RESET = 1'b0;
    localparam logic CTRL_CLOCK_MODE = 1'b1;
endpackage : irq_io_pkg
`default_nettype wire

// >>> hw/irq_io_top.sv
/*
 * Interrupt prioritiser with sixteen programmable ports behind a
 * bit-addressed serial bus. Assumes bus pins and strobe are asynchronous
 * to MCLK_I and the strobe is high for at least two clock periods.
 */
`default_nettype none
module irq_io_top
    import irq_io_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic [SEL_W-1:0] BIT_SELECT_CODE_I,
    input wire logic WRITE_DATA_I,
    input wire logic WRITE_STROBE_I,
    input wire logic [NUM_DED_IRQ-1:0] DEDICATED_IRQ_INPUTS_N_I,
    input wire logic [NUM_SHARED-1:0] SHARED_IRQ_PORT_PINS_I,
    output logic [NUM_SHARED-1:0] SHARED_IRQ_PORT_PINS_O,
    output logic [NUM_SHARED-1:0] SHARED_IRQ_PORT_PINS_OE_N_O,
    input wire logic [NUM_DED_PORT-1:0] DEDICATED_PORT_PINS_I,
    output logic [NUM_DED_PORT-1:0] DEDICATED_PORT_PINS_O,
    output logic [NUM_DED_PORT-1:0] DEDICATED_PORT_PINS_OE_N_O,
    output logic READ_DATA_O,
    output logic READ_DATA_OE_N_O,
    output logic INTERRUPT_REQUEST_N_O,
    output logic [3:0] PRIORITY_CODE_OUT_O,
    output logic CLOCK_MODE_O
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = NUM_DED_IRQ + NUM_SHARED + NUM_DED_PORT + SEL_W + 3;
    logic [NSYNC-1:0] raw_pins;
    logic [NSYNC-1:0] syn;
    logic [NUM_DED_IRQ-1:0] ded_irq_n;
    logic [NUM_SHARED-1:0] shared_in;
    logic [NUM_DED_PORT-1:0] ded_port_in;
    logic [SEL_W-1:0] sel;
    logic cs_n, wdata, strobe;

    assign raw_pins = {DEDICATED_IRQ_INPUTS_N_I, SHARED_IRQ_PORT_PINS_I,
                       DEDICATED_PORT_PINS_I, BIT_SELECT_CODE_I,
                       CHIP_SELECT_N_I, WRITE_DATA_I, WRITE_STROBE_I};

    pin_sync #(.W(NSYNC)) u_sync (
        .clk_i(MCLK_I),
        .rst_i(RST_I),
        .d_i(raw_pins),
        .q_o(syn)
    );

    assign {ded_irq_n, shared_in, ded_port_in, sel, cs_n, wdata, strobe} = syn;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ctrl;
        logic [NUM_IRQ-1:0] mask;
        logic [NUM_PORT-1:0] dir;
        logic [NUM_PORT-1:0] val;
        logic strobe_d;
        logic irq_n;
        logic [3:0] code;
        logic rdata;
        logic rdata_oe_n;
    } st_s;
    st_s st_q, st_d;

    // Port pin levels: port n is dedicated for n<7, shared pin (15-n) otherwise
    logic [NUM_PORT-1:0] port_pin;
    // Interrupt pins, index 0 is interrupt one
    logic [NUM_IRQ-1:0] irq_pin_n;
    logic [NUM_IRQ-1:0] irq_act;
    logic any_irq;
    logic [3:0] enc_code;

    genvar g;
    generate
        for (g = 0; g < NUM_SHARED; g++) begin : g_shared
            assign irq_pin_n[NUM_DED_IRQ + g] = shared_in[g];
            assign port_pin[NUM_PORT - 1 - g] = shared_in[g];
        end
    endgenerate
    assign irq_pin_n[NUM_DED_IRQ-1:0] = ded_irq_n;
    assign port_pin[NUM_DED_PORT-1:0] = ded_port_in;

    assign irq_act = ~irq_pin_n & st_q.mask;

    prio_encoder #(.N(NUM_IRQ)) u_enc (
        .req_i(irq_act),
        .any_o(any_irq),
        .code_o(enc_code)
    );

    function automatic logic port_sel(input logic [SEL_W-1:0] s);
        return s >= SEL_PORT_BASE;
    endfunction : port_sel

    // Read mux over the 32 bit positions
    function automatic logic read_bit(input logic [SEL_W-1:0] s, input st_s q,
                                      input logic [NUM_IRQ-1:0] pins_n,
                                      input logic [NUM_PORT-1:0] ports);
        logic r;
        r = 1'b0;
        if (port_sel(s)) begin
            r = ports[s[3:0]];
        end else if (s == SEL_CONTROL) begin
            r = q.ctrl;
        end else if (s == SEL_SOFT_RESET && q.ctrl == CTRL_CLOCK_MODE) begin
            r = q.irq_n;
        end else if (s != SEL_CONTROL) begin
            r = pins_n[4'(s) - 4'h1];
        end
        return r;
    endfunction : read_bit

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic wr_evt;
    logic [NUM_PORT-1:0] port_read;
    assign wr_evt = strobe & ~st_q.strobe_d & ~cs_n;
    generate
        for (g = 0; g < NUM_PORT; g++) begin : g_prd
            // Output ports read back their latched value
            assign port_read[g] = st_q.dir[g] ? st_q.val[g] : port_pin[g];
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.strobe_d = strobe;
        if (wr_evt) begin
            if (sel == SEL_CONTROL) begin
                st_d.ctrl = wdata;
            end else if (port_sel(sel)) begin
                st_d.dir[sel[3:0]] = 1'b1;
                st_d.val[sel[3:0]] = wdata;
            end else if (st_q.ctrl == CTRL_CLOCK_MODE) begin
                if (sel == SEL_SOFT_RESET && !wdata) begin
                    st_d.dir = PORT_DIR_RESET;
                end
            end else begin
                st_d.mask[4'(sel) - 4'h1] = wdata;
            end
        end
        // Interrupt outputs ignore chip select
        st_d.irq_n = ~any_irq;
        st_d.code = any_irq ? enc_code : CODE_IDLE;
        st_d.rdata = read_bit(sel, st_q, irq_pin_n, port_read);
        st_d.rdata_oe_n = cs_n;
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            st_q.ctrl <= CTRL_RESET;
            st_q.mask <= MASK_RESET;
            st_q.dir <= PORT_DIR_RESET;
            st_q.val <= PORT_VAL_RESET;
            st_q.strobe_d <= 1'b1;
            st_q.irq_n <= 1'b1;
            st_q.code <= CODE_RESET;
            st_q.rdata <= 1'b0;
            st_q.rdata_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    generate
        for (g = 0; g < NUM_SHARED; g++) begin : g_sho
            assign SHARED_IRQ_PORT_PINS_O[g] = st_q.val[NUM_PORT - 1 - g];
            assign SHARED_IRQ_PORT_PINS_OE_N_O[g] = ~st_q.dir[NUM_PORT - 1 - g];
        end
    endgenerate
    assign DEDICATED_PORT_PINS_O = st_q.val[NUM_DED_PORT-1:0];
    assign DEDICATED_PORT_PINS_OE_N_O = ~st_q.dir[NUM_DED_PORT-1:0];
    assign READ_DATA_O = st_q.rdata;
    assign READ_DATA_OE_N_O = st_q.rdata_oe_n;
    assign INTERRUPT_REQUEST_N_O = st_q.irq_n;
    assign PRIORITY_CODE_OUT_O = st_q.code;
    assign CLOCK_MODE_O = st_q.ctrl;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_req_low;
        @(posedge MCLK_I) disable iff (RST_I) (|irq_act) |=> !INTERRUPT_REQUEST_N_O;
    endproperty
    a_req_low: assert property (p_req_low) else $error("request not asserted");

    property p_req_high;
        @(posedge MCLK_I) disable iff (RST_I) !(|irq_act) |=> INTERRUPT_REQUEST_N_O;
    endproperty
    a_req_high: assert property (p_req_high) else $error("request not released");

    property p_code_one;
        @(posedge MCLK_I) disable iff (RST_I) irq_act[0] |=> PRIORITY_CODE_OUT_O == 4'h1;
    endproperty
    a_code_one: assert property (p_code_one) else $error("interrupt one not first");

    property p_idle_code;
        @(posedge MCLK_I) disable iff (RST_I)
            INTERRUPT_REQUEST_N_O && !$past(RST_I) |-> PRIORITY_CODE_OUT_O == CODE_IDLE;
    endproperty
    a_idle_code: assert property (p_idle_code) else $error("idle code not all ones");

    property p_code_match;
        @(posedge MCLK_I) disable iff (RST_I) any_irq |=> PRIORITY_CODE_OUT_O == $past(enc_code);
    endproperty
    a_code_match: assert property (p_code_match) else $error("code mismatch");

    property p_float;
        @(posedge MCLK_I) disable iff (RST_I) cs_n |=> READ_DATA_OE_N_O;
    endproperty
    a_float: assert property (p_float) else $error("read data driven while idle");

    property p_no_write_idle;
        @(posedge MCLK_I) disable iff (RST_I) cs_n |=> $stable(st_q.mask) && $stable(st_q.dir);
    endproperty
    a_no_write_idle: assert property (p_no_write_idle) else $error("write while deselected");

    property p_port_write;
        @(posedge MCLK_I) disable iff (RST_I) wr_evt && port_sel(sel)
            |=> st_q.dir[$past(sel[3:0])] && st_q.val[$past(sel[3:0])] == $past(wdata);
    endproperty
    a_port_write: assert property (p_port_write) else $error("port write lost");

    property p_soft_reset;
        @(posedge MCLK_I) disable iff (RST_I) wr_evt && sel == SEL_SOFT_RESET
            && st_q.ctrl && !wdata |=> st_q.dir == PORT_DIR_RESET;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset ignored");

    property p_reset_out;
        @(posedge MCLK_I) RST_I |=> INTERRUPT_REQUEST_N_O && PRIORITY_CODE_OUT_O == CODE_RESET
            && st_q.mask == MASK_RESET;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset state wrong");

    property p_mask_write;
        @(posedge MCLK_I) disable iff (RST_I) wr_evt && sel != SEL_CONTROL && !port_sel(sel)
            && st_q.ctrl != CTRL_CLOCK_MODE
            |=> st_q.mask[$past(4'(sel) - 4'h1)] == $past(wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_ctrl_write;
        @(posedge MCLK_I) disable iff (RST_I)
            wr_evt && sel == SEL_CONTROL |=> CLOCK_MODE_O == $past(wdata);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_clock_lock;
        @(posedge MCLK_I) disable iff (RST_I)
            wr_evt && st_q.ctrl == CTRL_CLOCK_MODE |=> $stable(st_q.mask);
    endproperty
    a_clock_lock: assert property (p_clock_lock) else $error("mask written in clock mode");

    property p_read_drive;
        @(posedge MCLK_I) disable iff (RST_I) !cs_n |=> !READ_DATA_OE_N_O;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read data not driven");

    property p_read_ctrl;
        @(posedge MCLK_I) disable iff (RST_I)
            !cs_n && sel == SEL_CONTROL |=> READ_DATA_O == $past(st_q.ctrl);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) else $error("control read wrong");

    property p_read_irq;
        @(posedge MCLK_I) disable iff (RST_I) !cs_n && sel != SEL_CONTROL && !port_sel(sel)
            && st_q.ctrl != CTRL_CLOCK_MODE
            |=> READ_DATA_O == $past(irq_pin_n[4'(sel) - 4'h1]);
    endproperty
    a_read_irq: assert property (p_read_irq) else $error("interrupt pin read wrong");

    property p_clock_read;
        @(posedge MCLK_I) disable iff (RST_I) !cs_n && sel == SEL_SOFT_RESET
            && st_q.ctrl == CTRL_CLOCK_MODE |=> READ_DATA_O == $past(st_q.irq_n);
    endproperty
    a_clock_read: assert property (p_clock_read) else $error("request read wrong");

    property p_read_port;
        @(posedge MCLK_I) disable iff (RST_I) !cs_n && port_sel(sel) && !st_q.dir[sel[3:0]]
            |=> READ_DATA_O == $past(port_pin[sel[3:0]]);
    endproperty
    a_read_port: assert property (p_read_port) else $error("input port read wrong");

    property p_cs_ignored;
        @(posedge MCLK_I) disable iff (RST_I)
            !$past(RST_I) && $changed(cs_n) && $stable(irq_act)
            |=> $stable(INTERRUPT_REQUEST_N_O) && $stable(PRIORITY_CODE_OUT_O);
    endproperty
    a_cs_ignored: assert property (p_cs_ignored) else $error("chip select moved outputs");

    property p_dir_sticky;
        @(posedge MCLK_I) disable iff (RST_I)
            !(wr_evt && sel == SEL_SOFT_RESET)
            |=> (st_q.dir & $past(st_q.dir)) == $past(st_q.dir);
    endproperty
    a_dir_sticky: assert property (p_dir_sticky) else $error("output port dropped");

    property p_ded_dir;
        @(posedge MCLK_I) disable iff (RST_I) wr_evt && port_sel(sel)
            && sel[3:0] < 4'(NUM_DED_PORT) |=> !DEDICATED_PORT_PINS_OE_N_O[$past(sel[2:0])];
    endproperty
    a_ded_dir: assert property (p_ded_dir) else $error("dedicated port not driven");

    property p_shared_dir;
        @(posedge MCLK_I) disable iff (RST_I) wr_evt && port_sel(sel)
            && sel[3:0] >= 4'(NUM_DED_PORT)
            |=> !SHARED_IRQ_PORT_PINS_OE_N_O[4'(NUM_PORT - 1) - $past(sel[3:0])];
    endproperty
    a_shared_dir: assert property (p_shared_dir) else $error("shared port not driven");

    c_irq: cover property (@(posedge MCLK_I) disable iff (RST_I) !INTERRUPT_REQUEST_N_O);
    c_port: cover property (@(posedge MCLK_I) disable iff (RST_I) wr_evt && port_sel(sel));
    c_soft: cover property (@(posedge MCLK_I) disable iff (RST_I)
        wr_evt && sel == SEL_SOFT_RESET && st_q.ctrl);
    c_read: cover property (@(posedge MCLK_I) disable iff (RST_I) !cs_n && !READ_DATA_OE_N_O);
    c_mask: cover property (@(posedge MCLK_I) disable iff (RST_I)
        wr_evt && sel != SEL_CONTROL && !port_sel(sel));
endmodule : irq_io_top
`default_nettype wire

// >>> hw/pin_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous pin levels.
 * Assumes the pins are unrelated to MCLK_I.
 */
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } st_s;
    st_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule : pin_sync
`default_nettype wire

// >>> hw/prio_encoder.sv
/*
 * Priority encoder: lowest set index wins, reports its number (1..15).
 * Assumes bit 0 of the request vector is interrupt one.
 */
`default_nettype none
module prio_encoder
    import irq_io_pkg::*;
#(
    parameter int N = NUM_IRQ
) (
    input wire logic [N-1:0] req_i,
    output logic any_o,
    output logic [3:0] code_o
);
    always_comb begin
        any_o = 1'b0;
        code_o = CODE_IDLE;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                code_o = 4'(i + 1);
            end
        end
    end
endmodule : prio_encoder
`default_nettype wire

// >>> tb/host_model.sv
/*
 * Host side of the bit-addressed bus: single-bit writes and reads.
 * Assumes one caller at a time and a running MCLK_I.
 */
`default_nettype none
module host_model
    import irq_io_pkg::*;
(
    input wire logic clk_i,
    input wire logic rd_data_i,
    input wire logic rd_oe_n_i,
    output logic cs_n_o,
    output logic [SEL_W-1:0] sel_o,
    output logic wdata_o,
    output logic strobe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sel_o = '0;
        wdata_o = 1'b0;
        strobe_o = 1'b0;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic release_bus();
        @(negedge clk_i);
        cs_n_o <= 1'b1;
        sel_o <= ~sel_o;
        wdata_o <= ~wdata_o;
    endtask : release_bus
    task automatic write_bit(input logic [SEL_W-1:0] sel, input logic d, input logic csn);
        @(negedge clk_i);
        cs_n_o <= csn;
        sel_o <= sel;
        wdata_o <= d;
        repeat (3) @(negedge clk_i);
        strobe_o <= 1'b1;
        repeat (3) @(negedge clk_i);
        strobe_o <= 1'b0;
        repeat (2) @(negedge clk_i);
        release_bus();
    endtask : write_bit
    task automatic read_bit(input logic [SEL_W-1:0] sel, output logic d, output logic oe_n);
        @(negedge clk_i);
        cs_n_o <= 1'b0;
        sel_o <= sel;
        repeat (5) @(negedge clk_i);
        d = rd_data_i;
        oe_n = rd_oe_n_i;
        release_bus();
    endtask : read_bit
endmodule : host_model
`default_nettype wire

// >>> tb/tb_top.sv
/*
 * Self-checking bench for the interrupt and port interface.
 * Assumes the host model drives the bus; pins are resolved here.
 */
`default_nettype none
module tb_top
    import irq_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, cs_n, wdata, strobe, rd, rd_oe_n, req_n, clk_mode, d, oe;
    logic [SEL_W-1:0] sel;
    logic [5:0] ded_irq_n = 6'h00;
    logic [8:0] shared_drv = 9'h1ff, sh_o, sh_oe_n, shared_lvl;
    logic [6:0] port_drv = 7'h00, dp_o, dp_oe_n, port_lvl;
    logic [3:0] code;
    int mismatches = 0;
    int check_count = 0;
    always #25 clk = ~clk;
    assign shared_lvl = (sh_oe_n & shared_drv) | (~sh_oe_n & sh_o);
    assign port_lvl = (dp_oe_n & port_drv) | (~dp_oe_n & dp_o);
    host_model u_host (.clk_i(clk), .rd_data_i(rd), .rd_oe_n_i(rd_oe_n), .cs_n_o(cs_n),
        .sel_o(sel), .wdata_o(wdata), .strobe_o(strobe));
    irq_io_top u_dut (.MCLK_I(clk), .RST_I(rst), .CHIP_SELECT_N_I(cs_n),
        .BIT_SELECT_CODE_I(sel), .WRITE_DATA_I(wdata), .WRITE_STROBE_I(strobe),
        .DEDICATED_IRQ_INPUTS_N_I(ded_irq_n), .SHARED_IRQ_PORT_PINS_I(shared_lvl),
        .SHARED_IRQ_PORT_PINS_O(sh_o), .SHARED_IRQ_PORT_PINS_OE_N_O(sh_oe_n),
        .DEDICATED_PORT_PINS_I(port_lvl), .DEDICATED_PORT_PINS_O(dp_o),
        .DEDICATED_PORT_PINS_OE_N_O(dp_oe_n), .READ_DATA_O(rd), .READ_DATA_OE_N_O(rd_oe_n),
        .INTERRUPT_REQUEST_N_O(req_n), .PRIORITY_CODE_OUT_O(code), .CLOCK_MODE_O(clk_mode));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (5) @(negedge clk);
    endtask : settle
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        repeat (10) @(negedge clk);
        chk(req_n, 1'b1);
        chk(code, CODE_RESET);
        chk({sh_oe_n, dp_oe_n}, 16'hffff);
        chk(rd_oe_n, 1'b1);
        repeat (10) @(negedge clk);
        rst <= 1'b0;
        settle();
        chk(req_n, 1'b1);
        chk(code, CODE_IDLE);
        ded_irq_n <= 6'h3f;
        $display("test_reset done");
    endtask : test_reset
    task automatic test_prio();
        u_host.write_bit(5'h01, 1'b1, 1'b0);
        u_host.write_bit(5'h03, 1'b1, 1'b0);
        u_host.write_bit(5'h05, 1'b1, 1'b0);
        ded_irq_n <= 6'h2b;
        settle();
        chk(code, 4'h3);
        chk(req_n, 1'b0);
        u_host.read_bit(5'h03, d, oe);
        chk({d, oe}, 2'b00);
        chk(code, 4'h3);
        ded_irq_n <= 6'h2a;
        settle();
        chk(code, 4'h1);
        ded_irq_n <= 6'h2f;
        settle();
        chk(code, 4'h5);
        ded_irq_n <= 6'h3f;
        settle();
        chk({req_n, code}, 5'h1f);
        u_host.write_bit(5'h03, 1'b0, 1'b0);
        ded_irq_n <= 6'h3b;
        settle();
        chk(req_n, 1'b1);
        ded_irq_n <= 6'h3f;
        u_host.write_bit(5'h0f, 1'b1, 1'b0);
        shared_drv <= 9'h0ff;
        settle();
        chk({req_n, code}, 5'h0f);
        shared_drv <= 9'h1ff;
        settle();
        $display("test_prio done");
    endtask : test_prio
    task automatic test_ports();
        u_host.write_bit(5'h10, 1'b1, 1'b0);
        u_host.write_bit(5'h1f, 1'b0, 1'b0);
        u_host.write_bit(5'h11, 1'b1, 1'b1);
        settle();
        chk({dp_oe_n[1:0], dp_o[0]}, 3'b101);
        chk({sh_oe_n[0], sh_o[0]}, 2'b00);
        port_drv <= 7'h04;
        u_host.read_bit(5'h12, d, oe);
        chk({d, oe}, 2'b10);
        u_host.read_bit(5'h10, d, oe);
        chk(d, 1'b1);
        settle();
        chk(rd_oe_n, 1'b1);
        $display("test_ports done");
    endtask : test_ports
    task automatic test_soft();
        u_host.write_bit(SEL_CONTROL, CTRL_CLOCK_MODE, 1'b0);
        settle();
        chk(clk_mode, 1'b1);
        u_host.read_bit(SEL_CONTROL, d, oe);
        chk(d, 1'b1);
        u_host.write_bit(SEL_SOFT_RESET, 1'b0, 1'b0);
        settle();
        chk({sh_oe_n, dp_oe_n}, 16'hffff);
        u_host.read_bit(SEL_SOFT_RESET, d, oe);
        chk({d, oe, req_n}, 3'b101);
        $display("test_soft done");
    endtask : test_soft
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        test_reset();
        test_prio();
        test_ports();
        test_soft();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
